// ### inc/uts_pkg.sv
// Constants, carriers and state types of the up-link telegram sequencer.
// Assumes one 40 MHz clock; every time figure is turned into cycles here.
package uts_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int CW_START_US = 150;
  localparam int AM_SILENT_US = 250;
  localparam int CW_START_CYC = CW_START_US * CYC_PER_US;
  localparam int AM_SILENT_CYC = AM_SILENT_US * CYC_PER_US;
  localparam int BIT_RATE_HZ = 564_480;
  localparam int BIT_CYC = (CLK_HZ + BIT_RATE_HZ / 2) / BIT_RATE_HZ;
  localparam logic [6:0] BIT_LAST = 7'(BIT_CYC - 1);
  localparam logic [7:0] MID_BLANK = 8'(BIT_CYC * 3 / 4);
  localparam logic [7:0] MID_LOST = 8'(BIT_CYC * 3 / 2);
  localparam logic [3:0] LOCK_BITS = 4'h8;
  localparam logic [7:0] FILL_MIN = 8'h4b;
  localparam logic [7:0] FILL_MAX = 8'h80;
  localparam logic [7:0] FILL_LEN = 8'h64;
  localparam logic [7:0] START_WAIT_BITS = 8'hc8;
  localparam logic [8:0] DEFAULT_DEADLINE_BITS = 9'h155;
  localparam int DEF_LEN = 1023;
  localparam logic [9:0] DEF_LAST = 10'(DEF_LEN - 1);
  localparam logic FILL_LEVEL = 1'b1;

  typedef enum logic [1:0] {MODE_IDLE, MODE_DECIDE, MODE_SEND, MODE_SILENT} uts_mode_t;
  typedef enum logic [1:0] {SRC_WAIT, SRC_FWD, SRC_FILL, SRC_DEFAULT} uts_src_t;

  typedef struct packed {
    logic energised;
    logic am_present;
    logic am_toggle;
    logic am_steady;
  } uts_power_t;

  typedef struct packed {
    logic strobe;
    logic value;
    logic ok;
  } uts_rx_bit_t;

  typedef struct packed {
    logic active;
    logic strobe;
    logic bit_val;
  } uts_air_t;
endpackage

// ### logic/uts_mode_classifier.sv
// Transmission mode decision from the kind of powering modulation.
// Assumes the analogue front end flags AM presence and its toggling class.
`timescale 1ns/1ps
module uts_mode_classifier #(
  parameter int SILENT_CYC = uts_pkg::AM_SILENT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input uts_pkg::uts_power_t power,
  output uts_pkg::uts_mode_t mode,
  output logic [13:0] decide_cnt
);
  import uts_pkg::*;

  uts_mode_t mode_reg;
  logic [13:0] cnt_reg;

  assign mode = mode_reg;
  assign decide_cnt = cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!resetn || !power.energised) begin
      mode_reg <= MODE_IDLE;
    end else begin
      case (mode_reg)
        MODE_IDLE: begin
          mode_reg <= power.am_present ? MODE_DECIDE : MODE_SEND;
        end
        MODE_DECIDE: begin
          if (power.am_toggle) begin
            mode_reg <= MODE_SEND;
          end else if (power.am_steady) begin
            mode_reg <= MODE_SILENT;
          end else if (cnt_reg == 14'(SILENT_CYC - 1)) begin
            mode_reg <= MODE_SEND;
          end
        end
        MODE_SEND: mode_reg <= MODE_SEND;
        MODE_SILENT: mode_reg <= MODE_SILENT;
        default: mode_reg <= MODE_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || mode_reg != MODE_DECIDE) begin
      cnt_reg <= 14'h0000;
    end else begin
      cnt_reg <= cnt_reg + 14'h0001;
    end
  end
endmodule

// ### logic/uts_biphase_decoder.sv
// Decoder for the differential bi-phase serial telegram line.
// Assumes the line is already synchronous to mclk and polarity free.
`timescale 1ns/1ps
module uts_biphase_decoder (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic line,
  output uts_pkg::uts_rx_bit_t rx
);
  import uts_pkg::*;

  logic line_reg;
  logic letter_reg;
  logic have_reg;
  logic [7:0] gap_reg;
  logic [3:0] lock_reg;
  uts_rx_bit_t rx_reg;
  logic mid;
  logic lost;

  // Edges closer than three quarters of a cell to the last centre edge are
  // cell boundaries; only centre edges carry a letter.
  assign mid = (line != line_reg) && (gap_reg >= MID_BLANK);
  assign lost = gap_reg >= MID_LOST;
  assign rx = rx_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!resetn || !enable) begin
      line_reg <= 1'b0;
      gap_reg <= 8'h00;
    end else begin
      line_reg <= line;
      if (mid) begin
        gap_reg <= 8'h00;
      end else if (gap_reg != 8'hff) begin
        gap_reg <= gap_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || !enable) begin
      letter_reg <= 1'b0;
      have_reg <= 1'b0;
      lock_reg <= 4'h0;
      rx_reg <= '0;
    end else begin
      rx_reg.strobe <= mid && have_reg;
      if (mid) begin
        letter_reg <= line;
        have_reg <= 1'b1;
        rx_reg.value <= (line == letter_reg);
      end else if (lost) begin
        have_reg <= 1'b0;
      end
      if (lost) begin
        lock_reg <= 4'h0;
      end else if (mid && lock_reg != LOCK_BITS) begin
        lock_reg <= lock_reg + 4'h1;
      end
      rx_reg.ok <= !lost && (lock_reg == LOCK_BITS);
    end
  end
endmodule

// ### logic/uts_sequencer.sv
// Up-link telegram sequencer: mode decision, forwarding, fill and default.
// Assumes synchronous inputs at 40 MHz and an external FSK modulator.
`timescale 1ns/1ps
module uts_sequencer #(
  parameter int SILENT_CYC = uts_pkg::AM_SILENT_CYC,
  parameter int CW_LIMIT_CYC = uts_pkg::CW_START_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input uts_pkg::uts_power_t power,
  input wire logic serial_telegram_input,
  input wire logic [uts_pkg::DEF_LEN-1:0] stored_telegram,
  output uts_pkg::uts_air_t uplink_air_gap_channel,
  output logic default_active
);
  import uts_pkg::*;

  uts_mode_t mode;
  logic [13:0] decide_cnt;
  uts_rx_bit_t rx;
  uts_src_t src_reg;
  uts_air_t air_reg;
  logic energised;
  logic send_en;
  logic tick;
  logic [6:0] bit_cnt_reg;
  logic [7:0] wait_bits_reg;
  logic [7:0] fill_cnt_reg;
  logic [8:0] since_bad_reg;
  logic [9:0] idx_reg;
  logic [DEF_LEN-1:0] def_mem_reg;
  logic [12:0] cw_wait_reg;

  assign energised = power.energised;
  assign send_en = (mode == MODE_SEND);
  assign tick = (bit_cnt_reg == BIT_LAST);
  assign uplink_air_gap_channel = air_reg;
  assign default_active = (src_reg == SRC_DEFAULT);

  ////////////////////////////////////////////////////////////////////////////
  uts_mode_classifier #(
    .SILENT_CYC(SILENT_CYC)
  ) u_mode (
    .mclk(mclk),
    .resetn(resetn),
    .power(power),
    .mode(mode),
    .decide_cnt(decide_cnt)
  );

  uts_biphase_decoder u_dec (
    .mclk(mclk),
    .resetn(resetn),
    .enable(energised),
    .line(serial_telegram_input),
    .rx(rx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Local bit clock for fill and default bits; forwarded bits keep the
  // lineside rate, so no buffer is needed between input and output.
  always_ff @(posedge mclk) begin
    if (!resetn || !energised || tick) begin
      bit_cnt_reg <= 7'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 7'h01;
    end
  end

  // The stored telegram is taken while unpowered so it is stable in a passage.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      def_mem_reg <= '0;
    end else if (!energised) begin
      def_mem_reg <= stored_telegram;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A run of ones alone cannot reveal the cell phase, so lock needs some zeros
  // from the lineside unit first; until then fill bits are sent, then the default telegram once the start wait and fill run end.
  always_ff @(posedge mclk) begin
    if (!resetn || !energised) begin
      src_reg <= SRC_WAIT;
    end else begin
      case (src_reg)
        SRC_WAIT: begin
          if (rx.ok) begin
            src_reg <= SRC_FWD;
          end else if (tick && wait_bits_reg == START_WAIT_BITS) begin
            src_reg <= SRC_FILL;
          end
        end
        SRC_FWD: begin
          if (!rx.ok) begin
            src_reg <= SRC_FILL;
          end
        end
        SRC_FILL: begin
          if (tick && fill_cnt_reg == FILL_LEN) begin
            src_reg <= SRC_DEFAULT;
          end
        end
        SRC_DEFAULT: src_reg <= SRC_DEFAULT;
        default: src_reg <= SRC_WAIT;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || src_reg != SRC_WAIT) begin
      wait_bits_reg <= 8'h00;
    end else if (tick && wait_bits_reg != START_WAIT_BITS) begin
      wait_bits_reg <= wait_bits_reg + 8'h01;
    end
  end

  // Counts constant bits already sent in the fill run.
  // Trailing ones from the lineside unit just before a loss lengthen the run;
  // the fixed count keeps the device's own share well inside the limits.
  always_ff @(posedge mclk) begin
    if (!resetn || src_reg != SRC_FILL) begin
      fill_cnt_reg <= 8'h00;
    end else if (tick && fill_cnt_reg != FILL_LEN) begin
      fill_cnt_reg <= fill_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || src_reg != SRC_DEFAULT) begin
      idx_reg <= 10'h000;
    end else if (tick) begin
      idx_reg <= (idx_reg == DEF_LAST) ? 10'h000 : idx_reg + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output bits are sent blind; the link carries no acknowledgement.
  always_ff @(posedge mclk) begin
    if (!resetn || !energised) begin
      air_reg <= '0;
    end else begin
      air_reg.active <= send_en;
      air_reg.strobe <= 1'b0;
      case (src_reg)
        SRC_FWD: begin
          air_reg.strobe <= rx.strobe && send_en;
          air_reg.bit_val <= rx.strobe ? rx.value : air_reg.bit_val;
        end
        SRC_WAIT, SRC_FILL: begin
          air_reg.strobe <= tick && send_en;
          air_reg.bit_val <= FILL_LEVEL;
        end
        SRC_DEFAULT: begin
          air_reg.strobe <= tick && send_en;
          air_reg.bit_val <= def_mem_reg[idx_reg];
        end
        default: air_reg.bit_val <= FILL_LEVEL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper counters read only by the checks below.
  always_ff @(posedge mclk) begin
    if (!resetn || src_reg == SRC_FWD || src_reg == SRC_DEFAULT || !energised) begin
      since_bad_reg <= 9'h000;
    end else if (tick) begin
      since_bad_reg <= since_bad_reg + 9'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || !energised || power.am_present || air_reg.active) begin
      cw_wait_reg <= 13'h0000;
    end else if (cw_wait_reg != 13'h1fff) begin
      cw_wait_reg <= cw_wait_reg + 13'h0001;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_cw_start_time: assert property (
    int'(cw_wait_reg) < CW_LIMIT_CYC)
    else $error("continuous wave start exceeded its time limit");

  a_cw_start_fast: assert property (
    $rose(energised) && !power.am_present ##1 energised [*3] |-> air_reg.active)
    else $error("transmission did not start after energisation");

  a_am_silence_bound: assert property (
    mode == MODE_DECIDE |-> !air_reg.active && int'(decide_cnt) < SILENT_CYC)
    else $error("amplitude modulation decision too long or not silent");

  a_nontoggle_silent: assert property (
    mode == MODE_SILENT |-> !air_reg.active && !air_reg.strobe)
    else $error("device transmits under non-toggling modulation");

  a_toggle_sends: assert property (
    mode == MODE_DECIDE && power.am_toggle && energised |=> mode == MODE_SEND)
    else $error("toggling modulation did not select sending");

  a_undecided_sends: assert property (
    mode == MODE_DECIDE && int'(decide_cnt) == SILENT_CYC - 1 && energised
      && !power.am_steady |=> mode == MODE_SEND)
    else $error("undecided modulation did not select sending");

  a_default_sticky: assert property (
    src_reg == SRC_DEFAULT && energised |=> src_reg == SRC_DEFAULT)
    else $error("default telegram abandoned while energised");

  a_fill_length: assert property (
    src_reg == SRC_FILL ##1 src_reg == SRC_DEFAULT
      |-> $past(fill_cnt_reg) >= FILL_MIN && $past(fill_cnt_reg) <= FILL_MAX)
    else $error("fill run length out of range");

  a_forward_same: assert property (
    src_reg == SRC_FWD && rx.strobe && send_en && energised
      |=> air_reg.strobe && air_reg.bit_val == $past(rx.value))
    else $error("forwarded bit lost or altered");

  a_default_deadline: assert property (
    since_bad_reg < DEFAULT_DEADLINE_BITS)
    else $error("default telegram later than its deadline");

  a_unpowered_reset: assert property (
    !energised |=> src_reg == SRC_WAIT && mode == MODE_IDLE && !air_reg.active)
    else $error("state not held in reset while unpowered");

  a_default_wrap: assert property (
    src_reg == SRC_DEFAULT && tick && idx_reg == DEF_LAST && energised
      |=> idx_reg == 10'h000)
    else $error("default telegram does not repeat cyclically");

  // Source, mode and output checks: each transition or output bit follows its trigger at the next edge; a_default_first checks the index in the first default cycle.
  a_wait_gives_up: assert property (
    src_reg == SRC_WAIT && !rx.ok && tick && wait_bits_reg == START_WAIT_BITS
      && energised |=> src_reg == SRC_FILL)
    else $error("no fallback after the start wait");

  a_lock_forwards: assert property (
    src_reg == SRC_WAIT && rx.ok && energised |=> src_reg == SRC_FWD)
    else $error("locked input not forwarded");

  a_loss_fills: assert property (
    src_reg == SRC_FWD && !rx.ok && energised |=> src_reg == SRC_FILL)
    else $error("input loss did not start the fill run");

  a_fill_constant: assert property (
    src_reg == SRC_FILL && tick && send_en && energised
      |=> air_reg.strobe && air_reg.bit_val == FILL_LEVEL)
    else $error("fill run bit not constant");

  a_default_first: assert property (
    src_reg == SRC_FILL ##1 src_reg == SRC_DEFAULT |-> idx_reg == 10'h000)
    else $error("default telegram did not start at its first bit");

  a_default_bit: assert property (
    src_reg == SRC_DEFAULT && tick && send_en && energised
      |=> air_reg.strobe && air_reg.bit_val == def_mem_reg[$past(idx_reg)])
    else $error("default telegram bit altered");

  a_send_held: assert property (
    mode == MODE_SEND && energised |=> mode == MODE_SEND && air_reg.active)
    else $error("transmission interrupted while energised");

  a_quiet_not_sending: assert property (
    !send_en |=> !air_reg.active && !air_reg.strobe)
    else $error("output active outside the sending mode");

  a_steady_silences: assert property (
    mode == MODE_DECIDE && power.am_steady && !power.am_toggle && energised
      |=> mode == MODE_SILENT)
    else $error("non-toggling modulation did not select silence");

  c_cw_sending: cover property (mode == MODE_SEND && src_reg == SRC_FWD && air_reg.strobe);
  c_silent: cover property (mode == MODE_SILENT);
  c_default_sent: cover property (src_reg == SRC_DEFAULT && air_reg.strobe);
  c_fwd_loss: cover property (src_reg == SRC_FWD ##1 src_reg == SRC_FILL);
  c_fill_default: cover property (src_reg == SRC_FILL ##1 src_reg == SRC_DEFAULT);
endmodule

// ### tb/uts_leu_model.sv
// Lineside encoder model driving the bi-phase serial telegram line.
// Assumes the bench offers next_bit and refills it after each took pulse.
`timescale 1ns/1ps
module uts_leu_model (
  input wire logic mclk,
  input wire logic enable,
  input wire logic next_bit,
  output logic line,
  output logic took
);
  logic letter_reg = 1'b0;
  logic en_reg = 1'b0;
  int cnt = 0;
  initial line = 1'b0;
  initial took = 1'b0;
  ////////////////////////////////////////////////////////////
  // The sender runs free and never waits on the device for anything.
  always @(posedge mclk) begin
    en_reg <= enable;
    took <= 1'b0;
    cnt <= 0;
    if (enable) begin
      cnt <= (cnt == 70) ? 0 : cnt + 1;
      if (cnt == 0) begin
        letter_reg <= next_bit ? letter_reg : !letter_reg;
        line <= next_bit ? letter_reg : !letter_reg;
        took <= 1'b1;
      end
      if (cnt == 35) line <= !letter_reg;
    end else if (en_reg) begin
      // A cut cable has no valid level, so flip once and stand still.
      line <= !line;
    end
  end
endmodule

// ### tb/uplink_telegram_sequencer_tb_top.sv
// Bench for the up-link telegram sequencer: modes, forwarding, default.
// Assumes the lineside encoder model and a 40 MHz clock.
`timescale 1ns/1ps
module uplink_telegram_sequencer_tb_top;
  import uts_pkg::*;
  localparam int SIL = 50;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  uts_power_t power = '0;
  logic ser;
  logic [DEF_LEN-1:0] stored;
  uts_air_t air;
  logic def_act;
  logic leu_en = 1'b0;
  logic leu_bit = 1'b0;
  logic took;
  logic [31:0] seed = 32'h909c_4b4e;
  logic [31:0] r;
  logic src_q[$];
  logic pq[$];
  logic dq[$];
  logic air_q[$];
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  int s;
  int a0;

  uts_sequencer #(.SILENT_CYC(SIL)) i_dut (
    .mclk(mclk), .resetn(resetn), .power(power), .serial_telegram_input(ser),
    .stored_telegram(stored), .uplink_air_gap_channel(air), .default_active(def_act)
  );
  uts_leu_model i_leu (
    .mclk(mclk), .enable(leu_en), .next_bit(leu_bit), .line(ser), .took(took)
  );

  always #12.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_act(int lim);
    n = 0;
    while (air.active !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Returns the first offset of p inside a, or -1.
  function automatic int find(ref logic a[$], ref logic p[$]);
    for (int o = 0; o + p.size() <= a.size(); o++) begin
      int j;
      j = 0;
      while (j < p.size() && a[o + j] === p[j]) j++;
      if (j == p.size()) return o;
    end
    return -1;
  endfunction

  ////////////////////////////////////////////////////////////
  // Output bits are logged and the encoder refilled on the sampling edge.
  always @(posedge mclk) begin
    cyc++;
    if (air.strobe === 1'b1) air_q.push_back(air.bit_val);
    if (took === 1'b1) leu_bit <= (src_q.size() > 0) ? src_q.pop_front() : 1'b0;
    if (cyc == 130000) begin
      fails++;
      finish_test();
    end
  end

  initial begin
    for (int i = 0; i < DEF_LEN; i++) begin
      r = rnd();
      stored[i] = r[0];
    end
    // The first default bit differs from the fill so the run ends cleanly.
    stored[0] = !FILL_LEVEL;
    repeat (5) tick();
    check("air in reset", 0, air);
    check("default in reset", 0, def_act);
    repeat (5) tick();
    resetn = 1'b1;
    for (int k = 0; k < 4; k++) begin
      power.am_present = (k != 0);
      power.energised = 1'b1;
      repeat (2) tick();
      if (k > 0) check("silent deciding", 0, air.active);
      if (k == 1 || k == 2) begin
        r = rnd();
        repeat (3 + r % 40) tick();
        power.am_toggle = (k == 1);
        power.am_steady = (k == 2);
        tick();
        power.am_steady = 1'b0;
        power.am_toggle = (k == 2);
        tick();
        power.am_toggle = 1'b0;
      end
      wait_act(k == 0 ? CW_START_CYC : (k == 1 ? 8 : (k == 2 ? 300 : SIL + 6)));
      check("mode send", k != 2, air.active);
      if (k == 3) check("decide time", 1, n > SIL - 10);
      a0 = 0;
      s = 0;
      repeat (213) begin
        tick();
        a0 += int'(air.strobe === 1'b1);
        s += int'(air.active === 1'b1);
      end
      check("bit strobes", (k != 2) ? 3 : 0, a0);
      check("active held", (k != 2) ? 213 : 0, s);
      power = '0;
      repeat (3) tick();
      check("idle unpowered", 0, air.active);
    end
    for (int i = 0; i < 150; i++) begin
      r = rnd();
      // Zeros lead: without boundary edges the decoder finds the cell phase.
      if (i < 20) src_q.push_back(1'b0);
      else pq.push_back((i >= 40 && i < 140) ? 1'b1 : r[0]);
    end
    src_q = {src_q, pq};
    air_q.delete();
    leu_en = 1'b1;
    power.energised = 1'b1;
    while (src_q.size() > 0) tick();
    repeat (300) tick();
    leu_en = 1'b0;
    n = 0;
    while (def_act !== 1'b1 && n < 341 * 71) begin
      tick();
      n++;
    end
    check("default start", 1, def_act);
    a0 = air_q.size();
    leu_en = 1'b1;
    while (air_q.size() < a0 + 1040) tick();
    check("default held", 1, def_act);
    check("forwarded stream", 1, find(air_q, pq) >= 0);
    for (int i = 0; i < 1030; i++) dq.push_back(stored[i % DEF_LEN]);
    s = find(air_q, dq);
    check("default cycling", 1, s > 0);
    n = 0;
    while (n < s && air_q[s - 1 - n] === FILL_LEVEL) n++;
    check("fill run", 1, n >= 75 && n <= 128);
    power = '0;
    repeat (3) tick();
    power.energised = 1'b1;
    repeat (3000) tick();
    check("fresh decision", 0, def_act);
    finish_test();
  end
endmodule
